// [tfc_top.sv]
// three-wire write-only configuration port for a dual low-pass filter
// assumes a host drives serial clock, data and enable asynchronously
`include "tfc_params.svh"

// How it works
// - sample data on rising serial clock while enabled
// - top two bits address the holding register
// - enable fall copies six low bits over
// - three 6-bit holding registers from one shifter
// - cutoff setting is one 10-bit word
// - gain splits into 3 dB and 0.5 dB steps
// - codes 00, 01, 11 pick A, B, gain
// - word A holds step low bits, chord
// - word B holds step high bits, osc test
// - gain code decodes 0 to 20.5 dB
module tfc_top (
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // serial pins
  input wire logic ser_clk_i,
  input wire logic ser_din_i,
  input wire logic ser_load_en_i,
  // frequency setting
  output logic [9:0] cutoff_word_o,
  output logic [2:0] chord_sel_o,
  output logic [6:0] step_sel_o,
  output logic osc_test_en_o,
  // gain setting
  output logic [5:0] gain_code_o,
  output logic [5:0] gain_half_db_o,
  output logic [2:0] gain_coarse_o,
  output logic [2:0] gain_fine_o,
  // word status
  output logic word_done_o,
  output logic word_len_err_o
);

  tfc_pins_if pins ();

  logic [`TFC_WORD_W-1:0] shift_q; // serial-in parallel-out register
  logic [3:0] bit_cnt_q; // bits seen this frame, saturating
  tfc_pkg::tfc_hold_t freq_a_q; // first frequency word
  tfc_pkg::tfc_hold_t freq_b_q; // second frequency word
  tfc_pkg::tfc_hold_t gain_q; // gain word
  tfc_pkg::tfc_addr_t addr; // decoded address of the shifted word
  tfc_pkg::tfc_hold_t data; // payload of the shifted word
  logic [5:0] gain_clamp; // gain code limited to the top step
  logic [5:0] half_db_q; // registered gain in 0.5 dB units
  logic [2:0] coarse_q; // registered count of 3 dB steps
  logic [2:0] fine_q; // registered count of 0.5 dB steps
  logic done_q; // one-cycle word complete pulse
  logic len_err_q; // last word was not exactly eight bits

  // pin synchroniser
  tfc_pin_sync #(
    .STAGES(`TFC_SYNC_STAGES)
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .ser_clk_i(ser_clk_i),
    .ser_din_i(ser_din_i),
    .ser_load_en_i(ser_load_en_i),
    .pins(pins)
  );

  // address and payload slices of the shifter
  assign addr = tfc_pkg::tfc_addr_t'(shift_q[`TFC_ADDR_HI:`TFC_ADDR_LO]);
  assign data = shift_q[`TFC_DATA_HI:0];

  // shifter: msb arrives first, so shift toward the top
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      shift_q <= '0;
    end else if (ce_i && pins.en && pins.sclk_rise) begin
      shift_q <= {shift_q[`TFC_WORD_W-2:0], pins.din};
    end
  end

  // bit counter, restarted when each frame ends
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bit_cnt_q <= '0;
    end else if (ce_i) begin
      if (pins.en_fall) begin
        bit_cnt_q <= '0;
      end else if (pins.en && pins.sclk_rise && bit_cnt_q != 4'hf) begin
        bit_cnt_q <= bit_cnt_q + 4'h1;
      end
    end
  end

  // holding registers; rst_i gives the all-zero word the host
  // would otherwise have to send first, but the host must still
  // program all three since a real part powers up undefined
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      freq_a_q <= `TFC_HOLD_RST;
      freq_b_q <= `TFC_HOLD_RST;
      gain_q <= `TFC_HOLD_RST;
    end else if (ce_i && pins.en_fall) begin
      unique case (addr)
        tfc_pkg::TFC_ADDR_FREQ_A: freq_a_q <= data;
        tfc_pkg::TFC_ADDR_FREQ_B: freq_b_q <= data;
        tfc_pkg::TFC_ADDR_GAIN: gain_q <= data;
        tfc_pkg::TFC_ADDR_UNDEF: begin
          // undefined code: leave every register alone
        end
      endcase
    end
  end

  // frame status: done pulse and length check
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      done_q <= 1'b0;
      len_err_q <= 1'b0;
    end else if (ce_i) begin
      done_q <= pins.en_fall;
      if (pins.en_fall) begin
        len_err_q <= (bit_cnt_q != 4'(`TFC_WORD_W));
      end
    end
  end

  // codes above the top step would exceed the gain range, so clamp
  assign gain_clamp = (gain_q > `TFC_GAIN_MAX_CODE) ?
                      `TFC_GAIN_MAX_CODE : gain_q;

  // gain decode into coarse 3 dB and fine 0.5 dB steps
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      half_db_q <= '0;
      coarse_q <= '0;
      fine_q <= '0;
    end else if (ce_i) begin
      half_db_q <= gain_clamp;
      coarse_q <= 3'(gain_clamp / `TFC_FINE_PER_COARSE);
      fine_q <= 3'(gain_clamp % `TFC_FINE_PER_COARSE);
    end
  end

  // field mapping of the frequency words; bit 4 of word B unused
  assign chord_sel_o = freq_a_q[`TFC_FA_CHORD_HI:`TFC_FA_CHORD_LO];
  assign step_sel_o = {freq_b_q[`TFC_FB_STEP_HI:`TFC_FB_STEP_LO],
                       freq_a_q[`TFC_FA_STEP_HI:`TFC_FA_STEP_LO]};
  assign osc_test_en_o = freq_b_q[`TFC_FB_OSC_BIT];
  assign cutoff_word_o = {chord_sel_o, step_sel_o};
  assign gain_code_o = gain_q;
  assign gain_half_db_o = half_db_q;
  assign gain_coarse_o = coarse_q;
  assign gain_fine_o = fine_q;
  assign word_done_o = done_q;
  assign word_len_err_o = len_err_q;

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_shift_sample: assert property (
    ce_i && pins.en && pins.sclk_rise |=>
      shift_q == {$past(shift_q[6:0]), $past(pins.din)})
    else $error("shifter did not take data on clock rise");

  a_shift_idle: assert property (
    !pins.en |=> $stable(shift_q))
    else $error("shifter moved while disabled");

  a_load_freq_a: assert property (
    ce_i && pins.en_fall && shift_q[7:6] == 2'h0 |=>
      freq_a_q == $past(shift_q[5:0]) && $stable(gain_q))
    else $error("word A not loaded on enable fall");

  a_load_freq_b: assert property (
    ce_i && pins.en_fall && shift_q[7:6] == 2'h1 |=>
      freq_b_q == $past(shift_q[5:0]) && $stable(freq_a_q))
    else $error("word B not loaded on enable fall");

  a_load_gain: assert property (
    ce_i && pins.en_fall && shift_q[7:6] == 2'h3 |=>
      gain_q == $past(shift_q[5:0]) && $stable(freq_b_q))
    else $error("gain word not loaded on enable fall");

  a_undef_addr: assert property (
    ce_i && pins.en_fall && shift_q[7:6] == 2'h2 |=>
      $stable(freq_a_q) && $stable(freq_b_q) && $stable(gain_q))
    else $error("undefined address changed a register");

  a_no_load_busy: assert property (
    !pins.en_fall |=> $stable(freq_a_q) && $stable(gain_q))
    else $error("holding register changed outside enable fall");

  a_cutoff_map: assert property (
    cutoff_word_o[2:0] == freq_a_q[5:3] &&
      cutoff_word_o[9:7] == freq_a_q[2:0] &&
      cutoff_word_o[6:3] == freq_b_q[3:0])
    else $error("cutoff word mapping broken");

  a_gain_split: assert property (
    ce_i ##1 ce_i |=>
      6'(gain_coarse_o) * 6'h06 + 6'(gain_fine_o) == gain_half_db_o &&
      gain_fine_o < 3'h6)
    else $error("gain coarse and fine do not add up");

  a_gain_track: assert property (
    ce_i && $changed(gain_q) && gain_q <= 6'h29 |=>
      gain_half_db_o == $past(gain_q))
    else $error("gain decode did not follow code");

  a_gain_ceiling: assert property (
    gain_half_db_o <= 6'h29)
    else $error("gain above 20.5 dB");

  a_freeze: assert property (
    !ce_i |=> $stable(shift_q) && $stable(freq_b_q) && $stable(half_db_q))
    else $error("state moved while clock enable low");

  c_load_a: cover property (ce_i && pins.en_fall && shift_q[7:6] == 2'h0);
  c_load_gain: cover property (ce_i && pins.en_fall && shift_q[7:6] == 2'h3);
  c_undef: cover property (ce_i && pins.en_fall && shift_q[7:6] == 2'h2);
  c_len_err: cover property (word_len_err_o);

endmodule

// [tfc_params.svh]
// constants for the three-wire filter configuration port
// assumes inclusion by bare name from any design file that needs it
`ifndef TFC_PARAMS_SVH
`define TFC_PARAMS_SVH

// serial word layout
`define TFC_WORD_W 8
`define TFC_DATA_W 6
`define TFC_ADDR_HI 7
`define TFC_ADDR_LO 6
`define TFC_DATA_HI 5

// first frequency word: low step bits and chord select
`define TFC_FA_STEP_HI 5
`define TFC_FA_STEP_LO 3
`define TFC_FA_CHORD_HI 2
`define TFC_FA_CHORD_LO 0

// second frequency word: high step bits and oscillator test bit
`define TFC_FB_STEP_HI 3
`define TFC_FB_STEP_LO 0
`define TFC_FB_OSC_BIT 5

// holding register value after rst_i (same as an all-zero word)
`define TFC_HOLD_RST 6'h00

// gain decode: 0.5 dB per code, 3 dB coarse step, 20.5 dB ceiling
`define TFC_FINE_PER_COARSE 6'h06
`define TFC_GAIN_MAX_CODE 6'h29

// synchroniser depth for pin inputs
`define TFC_SYNC_STAGES 2

`endif

// [tfc_pkg.sv]
// types shared by the filter configuration port modules
// assumes nothing beyond a SystemVerilog compiler
package tfc_pkg;

  // address code carried in the two top bits of each word
  typedef enum logic [1:0] {
    TFC_ADDR_FREQ_A = 2'h0,
    TFC_ADDR_FREQ_B = 2'h1,
    TFC_ADDR_UNDEF = 2'h2,
    TFC_ADDR_GAIN = 2'h3
  } tfc_addr_t;

  // one holding register
  typedef logic [5:0] tfc_hold_t;

endpackage

// [tfc_pins_if.sv]
// carrier between the pin synchroniser and the port core
// assumes both ends run on the same clk_i
interface tfc_pins_if;
  logic sclk_rise; // one-cycle pulse per rising serial clock edge
  logic din; // synchronised serial data level
  logic en; // synchronised load enable level
  logic en_fall; // one-cycle pulse per falling load enable edge

  // synchroniser side
  modport drv (
    output sclk_rise,
    output din,
    output en,
    output en_fall
  );

  // consumer side
  modport core (
    input sclk_rise,
    input din,
    input en,
    input en_fall
  );
endinterface

// [tfc_pin_sync.sv]
// pin synchroniser and edge finder for the three serial pins
// assumes pins are asynchronous to clk_i and slower than clk_i / 4
`include "tfc_params.svh"

module tfc_pin_sync #(
  parameter int STAGES = `TFC_SYNC_STAGES
) (
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // raw pins
  input wire logic ser_clk_i,
  input wire logic ser_din_i,
  input wire logic ser_load_en_i,
  // synchronised view
  tfc_pins_if.drv pins
);

  // refuse a chain too short to settle metastability
  if (STAGES < 2) begin : g_bad_depth
    $error("tfc_pin_sync: STAGES must be at least 2");
  end

  localparam int NPIN = 3;

  logic [NPIN-1:0] raw; // bit 0 clock, bit 1 data, bit 2 enable
  logic [STAGES-1:0][NPIN-1:0] stg_q; // chain, index 0 is first flop
  logic [NPIN-1:0] last_q; // previous settled value for edge finding

  assign raw = {ser_load_en_i, ser_din_i, ser_clk_i};

  // synchroniser chain; only stage 1 reads stage 0
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stg_q <= '0;
    end else if (ce_i) begin
      stg_q <= {stg_q[STAGES-2:0], raw};
    end
  end

  // history for edge detection, taken from the settled stage only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      last_q <= '0;
    end else if (ce_i) begin
      last_q <= stg_q[STAGES-1];
    end
  end

  // edges are gated by ce_i so a frozen block sees no phantom event
  assign pins.sclk_rise = ce_i & stg_q[STAGES-1][0] & ~last_q[0];
  assign pins.din = stg_q[STAGES-1][1];
  assign pins.en = stg_q[STAGES-1][2];
  assign pins.en_fall = ce_i & ~stg_q[STAGES-1][2] & last_q[2];

endmodule

// [tfc_host_model.sv]
// host controller model driving the three-wire configuration bus
// assumes clk_i is the 100 MHz system clock; serial clock is 80 ns
module tfc_host (
  // timing reference
  input wire logic clk_i,
  // serial bus pins
  output logic ser_clk_o,
  output logic ser_din_o,
  output logic ser_load_en_o
);
  timeunit 1ns;
  timeprecision 100ps;

  // bus idles with serial clock parked low and enable low
  initial begin
    ser_clk_o = 1'b0;
    ser_din_o = 1'b0;
    ser_load_en_o = 1'b0;
  end

  // one 40 ns phase, pins always move just after a clk_i edge
  task automatic half_phase();
    repeat (4) @(posedge clk_i);
    #1;
  endtask

  // one frame of n bits, msb first; n other than 8 breaks the framing
  task automatic send(input logic [15:0] bits, input int n);
    ser_load_en_o = 1'b1;
    half_phase();
    for (int i = n - 1; i >= 0; i--) begin
      ser_din_o = bits[i]; // data held through the whole high phase
      half_phase();
      ser_clk_o = 1'b1;
      half_phase();
      ser_clk_o = 1'b0;
    end
    half_phase(); // enable falls a full phase after the last clock fall
    ser_load_en_o = 1'b0;
    ser_din_o = ~ser_din_o; // released data must not look stable
    half_phase();
  endtask
endmodule

// [tfc_tb.sv]
// self-checking bench for the filter configuration port
// assumes tfc_top, tfc_pkg and tfc_host are compiled before it
module tb;
  timeunit 1ns;
  timeprecision 100ps;

  // expected view of every output but word_done_o after one frame
  typedef struct packed {
    logic [9:0] cut;
    logic [2:0] ch;
    logic [6:0] st;
    logic os;
    logic [5:0] gc, gh;
    logic [2:0] co, fi;
    logic le;
  } tfc_exp_t;

  logic clk_i = 1'b0; // system clock
  logic rst_i = 1'b1; // held at start
  logic ce_i = 1'b1; // lowered once to freeze the block
  wire logic ser_clk, ser_din, ser_en; // bus from the host model
  logic [9:0] cutoff_word_o;
  logic [2:0] chord_sel_o, gain_coarse_o, gain_fine_o;
  logic [6:0] step_sel_o;
  logic osc_test_en_o, word_done_o, word_len_err_o;
  logic [5:0] gain_code_o, gain_half_db_o;
  tfc_exp_t exp_q[$]; // notes written by the driver
  tfc_exp_t em; // note being compared
  logic [5:0] ra, rb, rg; // model holding registers
  logic [7:0] sr; // model shifter
  logic [5:0] gains [4] = '{6'h00, 6'h29, 6'h2a, 6'h3f}; // clamp edges
  int errors = 0;
  int n_checks = 0;

  always #5 clk_i = ~clk_i;

  tfc_host u_host (.clk_i(clk_i), .ser_clk_o(ser_clk), .ser_din_o(ser_din),
    .ser_load_en_o(ser_en));

  tfc_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .ser_clk_i(ser_clk), .ser_din_i(ser_din), .ser_load_en_i(ser_en),
    .cutoff_word_o(cutoff_word_o), .chord_sel_o(chord_sel_o),
    .step_sel_o(step_sel_o), .osc_test_en_o(osc_test_en_o),
    .gain_code_o(gain_code_o), .gain_half_db_o(gain_half_db_o),
    .gain_coarse_o(gain_coarse_o), .gain_fine_o(gain_fine_o),
    .word_done_o(word_done_o), .word_len_err_o(word_len_err_o));

  // verdict and end of run, the only exit
  task automatic summarize();
    if (errors == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // single comparison point, case equality so x never matches
  task automatic check(input logic [31:0] seen, exp, input string msg);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t %s %h/%h", $time, msg, seen, exp);
    end
  endtask

  // model the frame, note the outcome, then send it
  task automatic write(input logic [15:0] bits, input int n);
    tfc_exp_t e;
    for (int i = n - 1; i >= 0; i--) sr = {sr[6:0], bits[i]};
    case (sr[7:6])
      2'h0: ra = sr[5:0];
      2'h1: rb = sr[5:0];
      2'h3: rg = sr[5:0];
      default: ;
    endcase
    e.ch = ra[2:0];
    e.st = {rb[3:0], ra[5:3]};
    e.cut = {e.ch, e.st};
    e.os = rb[5];
    e.gc = rg;
    e.gh = (rg > 6'h29) ? 6'h29 : rg; // 41 half-dB units is 20.5 dB
    e.co = 3'(e.gh / 6);
    e.fi = 3'(e.gh % 6);
    e.le = (n != 8);
    exp_q.push_back(e);
    u_host.send(bits, n);
  endtask

  // reset for 16 cycles, model cleared alongside
  task automatic do_reset();
    @(posedge clk_i) #1 rst_i = 1'b1;
    repeat (16) @(posedge clk_i);
    #1 rst_i = 1'b0;
    {ra, rb, rg, sr} = '0;
    repeat (3) @(posedge clk_i);
    #1 check({cutoff_word_o, osc_test_en_o, gain_code_o, gain_half_db_o,
      word_len_err_o, word_done_o}, '0, "reset");
  endtask

  // bounded wait for every noted frame to be answered
  task automatic drain();
    for (int k = 0; k < 100 && exp_q.size() != 0; k++) @(posedge clk_i);
    if (exp_q.size() != 0) begin
      errors++;
      $display("CHECK FAILED t=%0t no answer for a frame", $time);
      summarize();
    end
  endtask

  // watcher: each done pulse answers the oldest note; done rises with
  // the load but the gain decode lags one cycle, so look a cycle later
  // and pop only then, so drain cannot end the run before the compare
  always @(posedge clk_i) begin
    #2;
    if (word_done_o === 1'b1) begin
      if (exp_q.size() == 0) begin
        errors++;
        $display("CHECK FAILED t=%0t unexpected done", $time);
      end else begin
        @(posedge clk_i);
        #2;
        em = exp_q[0];
        check({cutoff_word_o, chord_sel_o, step_sel_o},
          {em.cut, em.ch, em.st}, "frequency");
        check(osc_test_en_o, em.os, "osc test");
        check({gain_code_o, gain_half_db_o,
          gain_coarse_o, gain_fine_o}, {em.gc, em.gh, em.co, em.fi}, "gain");
        check(word_len_err_o, em.le, "length");
        em = exp_q.pop_front();
      end
    end
  end

  // hang guard
  initial begin
    #500000;
    errors++;
    $display("CHECK FAILED t=%0t run too long", $time);
    summarize();
  end

  // main sequence
  initial begin
    void'($urandom(32'h954d));
    do_reset();
    // all three registers written first after power-up
    write({10'h0, 6'($urandom)}, 8);
    write({10'h1, 6'($urandom)}, 8);
    write({10'h3, 6'($urandom)}, 8);
    foreach (gains[i]) write({10'h3, gains[i]}, 8);
    repeat (12) write({8'h0, 8'($urandom)}, 8); // random words, any code
    write(16'h00bf, 8);
    write(16'h0015, 5); // short frame keeps older shifter bits
    write(16'h02c7, 10); // long frame keeps only the last eight
    drain();
    // a frame sent while the clock enable is low must leave no trace
    #1 ce_i = 1'b0;
    u_host.send(16'h00c5, 8);
    ce_i = 1'b1;
    repeat (8) @(posedge clk_i);
    #1 check({cutoff_word_o, gain_code_o, word_len_err_o},
      {ra[2:0], rb[3:0], ra[5:3], rg, 1'b1}, "frozen frame");
    do_reset(); // second reset in mid-run
    write(16'h0055, 8);
    drain();
    summarize();
  end
endmodule
